// file: inc/timers_pkg.sv
// Package for the idle timer and the two PWM timer blocks.
// Assumes a single 50 MHz system clock and a plain register port.
package timers_pkg;
	localparam int ADDR_W = 4;
	// Register indices on the plain register port
	localparam logic [3:0] ADDR_IDLE_MODE   = 4'h0;
	localparam logic [3:0] ADDR_INT_CTRL    = 4'h1;
	localparam logic [3:0] ADDR_SPEED_CTRL  = 4'h2;
	localparam logic [3:0] ADDR_T1_CTRL     = 4'h3;
	localparam logic [3:0] ADDR_T1_CNT_LO   = 4'h4;
	localparam logic [3:0] ADDR_T1_CNT_HI   = 4'h5;
	localparam logic [3:0] ADDR_T1_RA_LO    = 4'h6;
	localparam logic [3:0] ADDR_T1_RA_HI    = 4'h7;
	localparam logic [3:0] ADDR_T1_RB_LO    = 4'h8;
	localparam logic [3:0] ADDR_T1_RB_HI    = 4'h9;
	localparam logic [3:0] ADDR_T2_BASE_OFS = 4'h6;
	// Field positions
	localparam int PERIOD_SEL_LSB  = 0;
	localparam int RESERVED_BIT    = 3;
	localparam int CLK_MODE_LSB    = 4;
	localparam int IDLE_PEND_BIT   = 5;
	localparam int IDLE_EN_BIT     = 4;
	localparam int GLOBAL_EN_BIT   = 0;
	localparam int TWO_FAST_BIT    = 0;
	localparam int WAKE_BIT        = 6;
	// Timer control byte: run, mode bits 1..3, pend A/B, enable A/B
	localparam int RUN_BIT   = 0;
	localparam int MODE_LSB  = 1;
	localparam int PEND_A    = 4;
	localparam int EN_A      = 5;
	localparam int PEND_B    = 6;
	localparam int EN_B      = 7;
	// Reset values
	localparam logic [7:0] IDLE_MODE_RST  = 8'hF0;
	localparam logic [7:0] SPEED_CTRL_RST = 8'h00;
	localparam logic [7:0] INT_CTRL_RST   = 8'h00;
	localparam logic [7:0] TIMER_CTRL_RST = 8'h00;
	localparam logic [7:0] PORT_G_RST     = 8'hFF;
	// Clock rates
	localparam int CLK_HZ      = 50_000_000;
	localparam int OSC_HZ      = 10_000_000;
	localparam int INSTR_DIV   = 5;
	localparam int SLOW_HZ     = 32_768;
	localparam int INSTR_HZ    = OSC_HZ / INSTR_DIV;
	localparam int FAST_HZ     = OSC_HZ * 2;
	localparam int INSTR_TICKS = CLK_HZ / INSTR_HZ;
	localparam int FAST_TICKS  = (CLK_HZ + FAST_HZ - 1) / FAST_HZ;
	localparam int SLOW_TICKS  = CLK_HZ / SLOW_HZ;
	localparam int IDLE_BIT_MIN = 11;

	typedef enum logic [2:0] {
		MODE_PWM_TOGGLE = 3'b101,
		MODE_PWM_QUIET  = 3'b100
	} timer_mode_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_s;
endpackage : timers_pkg

// file: src/idle_and_pwm_timers.sv
// Idle timer plus two PWM timer blocks behind a byte register port.
// Assumes a synchronous master; pin_b and slow_clk_in arrive asynchronously.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
module idle_and_pwm_timers #(
	parameter int TIMER_W = 16
) (
	input  wire logic                clk,
	input  wire logic                rst_b,
	input  wire timers_pkg::reg_req_s req,
	output logic [7:0]               rdata,
	input  wire logic                low_speed_mode,
	input  wire logic                slow_clk_in,
	input  wire logic [1:0]          pin_b_in,
	output logic [1:0]               pin_a_out,
	output logic [1:0]               pin_a_oe,
	output logic                     idle_irq,
	output logic [1:0]               timer_irq,
	output logic                     wake_bit,
	output logic                     soft_reset_req
);
	localparam int T = 2;

	// Tick generators: 2 MHz instruction, 20 MHz fast, 32 kHz slow
	logic [7:0]  instr_cnt_r;
	logic [7:0]  fast_cnt_r;
	logic [1:0]  slow_sync_r;
	logic        slow_last_r;
	wire         instr_tick = (instr_cnt_r == 8'(timers_pkg::INSTR_TICKS - 1));
	wire         fast_tick  = (fast_cnt_r == 8'(timers_pkg::FAST_TICKS - 1));
	wire         slow_tick  = slow_sync_r[1] & ~slow_last_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			instr_cnt_r <= 8'h00;
			fast_cnt_r  <= 8'h00;
			slow_sync_r <= 2'h0;
			slow_last_r <= 1'b0;
		end else begin
			if (instr_tick) begin
				instr_cnt_r <= 8'h00;
			end else begin
				instr_cnt_r <= instr_cnt_r + 8'h01;
			end
			// The fast tick rounds up to every 3 clocks, so timer two runs a sixth slow
			if (fast_tick) begin
				fast_cnt_r <= 8'h00;
			end else begin
				fast_cnt_r <= fast_cnt_r + 8'h01;
			end
			slow_sync_r <= {slow_sync_r[0], slow_clk_in};
			slow_last_r <= slow_sync_r[1];
		end
	end

	// Pin B is synchronised though no logic here uses it
	logic [1:0] pin_b_s1_r;
	logic [1:0] pin_b_s2_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_b_s1_r <= 2'h0;
			pin_b_s2_r <= 2'h0;
		end else begin
			pin_b_s1_r <= pin_b_in;
			pin_b_s2_r <= pin_b_s1_r;
		end
	end

	// Register writes
	wire wr_idle_mode = req.wr && req.addr == timers_pkg::ADDR_IDLE_MODE;
	wire wr_int_ctrl  = req.wr && req.addr == timers_pkg::ADDR_INT_CTRL;
	wire wr_speed     = req.wr && req.addr == timers_pkg::ADDR_SPEED_CTRL;

	logic [7:0] idle_mode_r;
	logic [7:0] int_ctrl_r;
	logic [7:0] speed_r;
	logic       wake_r;
	logic       soft_rst_r;

	// Idle timer: free running, not visible to software
	logic [15:0] idle_cnt_r;
	logic [15:0] idle_cnt_nxt;
	wire  [2:0]  period_sel = idle_mode_r[timers_pkg::PERIOD_SEL_LSB +: 3];
	wire         idle_tick  = low_speed_mode ? slow_tick : instr_tick;
	wire  [3:0]  sel_idx    = 4'(timers_pkg::IDLE_BIT_MIN) + {1'b0, period_sel};
	assign idle_cnt_nxt = idle_cnt_r - 16'h0001;
	// Reserved codes fall back to bit 15 rather than stalling the timer
	wire  [3:0]  sel_bit = (period_sel > 3'h4) ? 4'hF : sel_idx;
	// The selected bit falls only when every bit below it is already zero
	wire  [15:0] low_mask  = (16'h0001 << sel_bit) - 16'h0001;
	wire         low_zero  = (idle_cnt_r & low_mask) == 16'h0000;
	wire         bit_falls = idle_cnt_r[sel_bit] && !idle_cnt_nxt[sel_bit];
	wire         idle_uf   = idle_tick && bit_falls && low_zero;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			idle_cnt_r <= 16'hFFFF;
		end else if (idle_tick) begin
			idle_cnt_r <= idle_cnt_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			idle_mode_r <= timers_pkg::IDLE_MODE_RST;
		end else if (wr_idle_mode) begin
			idle_mode_r <= req.wdata;
		end
	end

	// Zeros in the clock-mode nibble request a device reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr_idle_mode && req.wdata[7:4] == 4'h0;
		end
	end

	// Hardware set of the pending bit wins over a simultaneous clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			int_ctrl_r <= timers_pkg::INT_CTRL_RST;
		end else begin
			if (wr_int_ctrl) begin
				int_ctrl_r <= req.wdata;
			end
			if (idle_uf) begin
				int_ctrl_r[timers_pkg::IDLE_PEND_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			speed_r <= timers_pkg::SPEED_CTRL_RST;
		end else if (wr_speed) begin
			speed_r <= {7'h00, req.wdata[timers_pkg::TWO_FAST_BIT]};
		end
	end

	// Stands in for the port G wake bit; an underflow beats a software set
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_r <= 1'b1;
		end else if (idle_uf) begin
			wake_r <= 1'b0;
		end else if (wr_int_ctrl && req.wdata[timers_pkg::WAKE_BIT]) begin
			wake_r <= 1'b1;
		end
	end

	assign idle_irq = int_ctrl_r[timers_pkg::IDLE_PEND_BIT]
	                & int_ctrl_r[timers_pkg::IDLE_EN_BIT]
	                & int_ctrl_r[timers_pkg::GLOBAL_EN_BIT];
	assign wake_bit       = wake_r;
	assign soft_reset_req = soft_rst_r;

	// General timers
	logic [7:0]         tctrl_r [T];
	logic [TIMER_W-1:0] cnt_r   [T];
	logic [TIMER_W-1:0] rla_r   [T];
	logic [TIMER_W-1:0] rlb_r   [T];
	logic [T-1:0]       next_b_r;
	logic [T-1:0]       pin_r;

	// Timer blocks sit one seven-byte register span apart
	function automatic logic [3:0] tbase(input int i);
		tbase = 4'(int'(timers_pkg::ADDR_T1_CTRL) + i * (int'(timers_pkg::ADDR_T2_BASE_OFS) + 1));
	endfunction : tbase

	for (genvar i = 0; i < T; i++) begin : g_tmr
		wire [3:0]         base       = tbase(i);
		wire [3:0]         last       = base + 4'h6;
		wire               wr_ctl     = req.wr && req.addr == base;
		wire               wr_cnt_lo  = req.wr && req.addr == base + 4'h1;
		wire               wr_cnt_hi  = req.wr && req.addr == base + 4'h2;
		wire               wr_rla_lo  = req.wr && req.addr == base + 4'h3;
		wire               wr_rla_hi  = req.wr && req.addr == base + 4'h4;
		wire               wr_rlb_lo  = req.wr && req.addr == base + 4'h5;
		// Timer two's last byte would wrap onto the idle mode register
		wire               wr_rlb_hi  = req.wr && req.addr == last && last > base;
		wire [2:0]         mode       = tctrl_r[i][timers_pkg::MODE_LSB +: 3];
		wire               pwm        = mode == timers_pkg::MODE_PWM_TOGGLE
		                             || mode == timers_pkg::MODE_PWM_QUIET;
		wire               fast       = (i == 1) && speed_r[timers_pkg::TWO_FAST_BIT];
		wire               run        = tctrl_r[i][timers_pkg::RUN_BIT];
		wire               tick       = (fast ? fast_tick : instr_tick) && pwm && run;
		wire               uf         = tick && cnt_r[i] == '0;
		wire               set_a      = uf && !next_b_r[i];
		wire               set_b      = uf && next_b_r[i];
		wire               toggle     = uf && mode == timers_pkg::MODE_PWM_TOGGLE;
		wire [TIMER_W-1:0] reload_val = next_b_r[i] ? rlb_r[i] : rla_r[i];
		logic [TIMER_W-1:0] cnt_nxt;

		// Software writes beat counting; stop the timer before touching it
		always_comb begin
			cnt_nxt = cnt_r[i];
			if (wr_cnt_lo) begin
				cnt_nxt[7:0] = req.wdata;
			end else if (wr_cnt_hi) begin
				cnt_nxt[15:8] = req.wdata;
			end else if (uf) begin
				cnt_nxt = reload_val;
			end else if (tick) begin
				cnt_nxt = cnt_r[i] - TIMER_W'(1);
			end
		end

		// Counter and reloads have no reset and power up arbitrary
		always_ff @(posedge clk) begin
			cnt_r[i] <= cnt_nxt;
		end

		always_ff @(posedge clk) begin
			if (wr_rla_lo) begin
				rla_r[i][7:0] <= req.wdata;
			end
			if (wr_rla_hi) begin
				rla_r[i][15:8] <= req.wdata;
			end
			if (wr_rlb_lo) begin
				rlb_r[i][7:0] <= req.wdata;
			end
			if (wr_rlb_hi) begin
				rlb_r[i][15:8] <= req.wdata;
			end
		end

		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				tctrl_r[i]  <= timers_pkg::TIMER_CTRL_RST;
				next_b_r[i] <= 1'b0;
				pin_r[i]    <= 1'b0;
			end else begin
				if (wr_ctl) begin
					tctrl_r[i] <= req.wdata;
				end
				// Hardware set wins over a simultaneous software clear
				if (set_a) begin
					tctrl_r[i][timers_pkg::PEND_A] <= 1'b1;
				end
				if (set_b) begin
					tctrl_r[i][timers_pkg::PEND_B] <= 1'b1;
				end
				// Stopping the timer rearms the A-first reload order
				if (!run) begin
					next_b_r[i] <= 1'b0;
				end else if (uf) begin
					next_b_r[i] <= ~next_b_r[i];
				end
				if (toggle) begin
					pin_r[i] <= ~pin_r[i];
				end
			end
		end

		assign timer_irq[i] = (tctrl_r[i][timers_pkg::PEND_A] & tctrl_r[i][timers_pkg::EN_A])
		                    | (tctrl_r[i][timers_pkg::PEND_B] & tctrl_r[i][timers_pkg::EN_B]);
		assign pin_a_out[i] = pin_r[i];
		assign pin_a_oe[i]  = pwm;
	end

	// Read mux, one cycle later
	function automatic logic [7:0] tread(input logic [3:0] ofs, input int i);
		case (ofs)
			4'h0:    tread = tctrl_r[i];
			4'h1:    tread = cnt_r[i][7:0];
			4'h2:    tread = cnt_r[i][15:8];
			4'h3:    tread = rla_r[i][7:0];
			4'h4:    tread = rla_r[i][15:8];
			4'h5:    tread = rlb_r[i][7:0];
			4'h6:    tread = rlb_r[i][15:8];
			default: tread = 8'h00;
		endcase
	endfunction : tread

	wire [3:0] ofs1     = req.addr - timers_pkg::ADDR_T1_CTRL;
	wire [3:0] ofs2     = req.addr - (timers_pkg::ADDR_T1_CTRL + timers_pkg::ADDR_T2_BASE_OFS + 4'h1);
	wire       hit_idle = req.addr == timers_pkg::ADDR_IDLE_MODE;
	wire       hit_int  = req.addr == timers_pkg::ADDR_INT_CTRL;
	wire       hit_spd  = req.addr == timers_pkg::ADDR_SPEED_CTRL;
	wire       hit_t1   = ofs1 < 4'h7;
	// Timer two's reload B high byte has no address of its own
	wire       hit_t2   = ofs2 < 4'h6;
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (hit_idle) begin
			rd_mux = idle_mode_r;
		end else if (hit_int) begin
			rd_mux = int_ctrl_r;
		end else if (hit_spd) begin
			rd_mux = speed_r;
		end else if (hit_t1) begin
			rd_mux = tread(ofs1, 0);
		end else if (hit_t2) begin
			rd_mux = tread(ofs2, 1);
		end
	end

	// Read data stands for one cycle only, zero otherwise
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			rdata <= rd_mux;
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule : idle_and_pwm_timers

// file: test/timers_properties.sv
// Port assertions for the idle and PWM timer block.
// Assumes one clock and an async active-low reset.
`timescale 1ns/10ps
module timers_properties (
	input wire logic			clk,
	input wire logic			rst_b,
	input wire timers_pkg::reg_req_s	req,
	input wire logic [7:0]		rdata,
	input wire logic [1:0]		pin_a_out,
	input wire logic [1:0]		pin_a_oe,
	input wire logic			idle_irq,
	input wire logic [1:0]		timer_irq,
	input wire logic			wake_bit,
	input wire logic			soft_reset_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_speed_upper_zero: assert property (
		$past(req.rd) && $past(req.addr) == 4'h2 |-> rdata[7:1] == 7'h00)
		else $error("speed upper bits set");
	a_reset_req_cause: assert property (
		soft_reset_req |-> $past(req.wr) && $past(req.addr) == 4'h0 && $past(req.wdata[7:4]) == 4'h0)
		else $error("stray reset request");
	a_reset_req_issue: assert property (
		req.wr && req.addr == 4'h0 && req.wdata[7:4] == 4'h0 |=> soft_reset_req)
		else $error("missing reset request");
	a_toggle_in_pwm: assert property (
		$changed(pin_a_out[0]) |-> $past(pin_a_oe[0])) else $error("pin moved outside pwm");
	a_idle_irq_rise: assert property (
		$rose(idle_irq) |-> $past(req.wr) || $past(req.wr, 2) || !wake_bit)
		else $error("idle irq rose without cause");
	a_idle_irq_fall: assert property (
		$fell(idle_irq) |-> $past(req.wr) || $past(req.wr, 2)) else $error("idle irq fell");
	a_timer_irq_sticky: assert property (
		$fell(timer_irq[0]) || $fell(timer_irq[1]) |-> $past(req.wr) || $past(req.wr, 2))
		else $error("timer irq fell");
	a_wake_set_write: assert property (
		$rose(wake_bit) |-> $past(req.wr) && $past(req.addr) == 4'h1) else $error("wake set");
	c_reset_req: cover property (soft_reset_req);
	c_wake_clear: cover property ($fell(wake_bit));
	c_timer_irq: cover property ($rose(timer_irq[0]));
endmodule : timers_properties

// file: test/idle_and_pwm_timers_tb_top.sv
// Bench: register-port tasks drive the timer block and check replies.
// The 32 kHz input toggles every clock so idle periods stay short.
`timescale 1ns/10ps
module idle_and_pwm_timers_tb_top;
	logic			clk, rst_b, low_speed_mode, slow_clk_in, idle_irq, wake_bit, soft_reset_req;
	logic [1:0]		pin_b_in, pin_a_out, pin_a_oe, timer_irq;
	logic [7:0]		rdata;
	timers_pkg::reg_req_s	req;
	int			miscompares = 0, checks_done = 0, cyc = 0, t1, t2;
	// Counter, reload A, reload B as lo/hi byte pairs
	localparam logic [7:0] INIT [6] = '{8'h01, 8'h00, 8'h03, 8'h00, 8'h07, 8'h00};
	idle_and_pwm_timers u_idle_and_pwm_timers (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata),
		.low_speed_mode(low_speed_mode), .slow_clk_in(slow_clk_in), .pin_b_in(pin_b_in),
		.pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .idle_irq(idle_irq), .timer_irq(timer_irq),
		.wake_bit(wake_bit), .soft_reset_req(soft_reset_req));
	task end_of_test;
		if (miscompares == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			miscompares++;
			$display("ERROR %0t: saw %0h want %0h", $time, seen, want);
		end
	endtask : chk
	// Two idle edges after a write let registered outputs settle
	task wr(input logic [3:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req <= '0;
		repeat (2) @(posedge clk);
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] w);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
		chk(32'(rdata & m), 32'(w));
	endtask : rd
	task wait_ev(input int sel);
		logic [1:0] p;
		p = pin_a_out;
		@(posedge clk);
		while ((sel == 2) ? (idle_irq !== 1'b1) : (pin_a_out[sel] === p[sel])) @(posedge clk);
	endtask : wait_ev
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		slow_clk_in <= ~slow_clk_in;
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		req = '0;
		rst_b = 1'b0;
		low_speed_mode = 1'b1;
		slow_clk_in = 1'b0;
		pin_b_in = 2'b00;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(4'h0, 8'hFF, 8'hF0);
		rd(4'h1, 8'hFF, 8'h00);
		rd(4'h2, 8'hFF, 8'h00);
		wr(4'h0, 8'h00);
		wr(4'h0, 8'hF0);
		wr(4'h2, 8'hFF);
		rd(4'h2, 8'hFF, 8'h01);
		wr(4'h1, 8'h11);
		wait_ev(2);
		t1 = cyc;
		chk(32'(wake_bit), 32'h0);
		rd(4'h1, 8'h20, 8'h20);
		wr(4'h1, 8'h21);
		chk(32'(idle_irq), 32'h0);
		wr(4'h1, 8'h30);
		chk(32'(idle_irq), 32'h0);
		wr(4'h1, 8'h51);
		chk(32'({wake_bit, idle_irq}), 32'h2);
		wait_ev(2);
		chk(cyc - t1, 8192);
		wr(4'h1, 8'h01);
		wr(4'h0, 8'hF1);
		wr(4'h1, 8'h11);
		wait_ev(2);
		t1 = cyc;
		wr(4'h1, 8'h11);
		wait_ev(2);
		chk(cyc - t1, 16384);
		for (int i = 0; i < 6; i++) begin
			wr(4'h4 + 4'(i), INIT[i]);
		end
		wr(4'h3, 8'h0B);
		wait_ev(0);
		t1 = cyc;
		rd(4'h3, 8'h50, 8'h10);
		wait_ev(0);
		t2 = cyc;
		wait_ev(0);
		chk((cyc - t2) - (t2 - t1), 100);
		rd(4'h3, 8'h50, 8'h50);
		chk(32'(timer_irq), 32'h0);
		wr(4'h3, 8'h7B);
		chk(32'(timer_irq), 32'h1);
		wr(4'h3, 8'hDB);
		chk(32'(timer_irq), 32'h1);
		// Stopped with both enables on: any underflow would raise the request
		wr(4'h3, 8'hAA);
		repeat (400) @(posedge clk);
		chk(32'(timer_irq), 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(4'hB + 4'(i), INIT[i + 2]);
		end
		wr(4'hA, 8'h0B);
		t1 = cyc;
		wait_ev(1);
		wr(4'hA, 8'h00);
		chk(32'(cyc - t1 < 40), 32'h1);
		end_of_test();
	end
endmodule : idle_and_pwm_timers_tb_top
bind idle_and_pwm_timers timers_properties u_timers_properties (.clk(clk), .rst_b(rst_b),
	.req(req), .rdata(rdata), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .idle_irq(idle_irq),
	.timer_irq(timer_irq), .wake_bit(wake_bit), .soft_reset_req(soft_reset_req));
